/* File: router_map.vh */
// register offsets, field positions and decode constants of the router
`ifndef ROUTER_MAP_VH
`define ROUTER_MAP_VH

// ************************************************************
// register offsets (byte addresses, one word each)
// ************************************************************
`define OFS_STATUS    8'h00
`define OFS_MASK      8'h04
`define OFS_JUMPERS   8'h08
`define OFS_STATE     8'h0C

// ************************************************************
// event bit positions in status and mask
// ************************************************************
`define EV_MEM        0
`define EV_IACK       1
`define EV_NOACK      2
`define EV_CFG        3
`define EV_W          4

// ************************************************************
// reset values
// ************************************************************
`define STATUS_RST    4'h0
`define MASK_RST      4'h0
`define SEL_IDLE      4'hF
`define IRQ_IDLE      7'h7F

// ************************************************************
// memory decode and interrupt levels
// ************************************************************
`define SZ_MIN        3'h1
`define SZ_MAX        3'h5
`define A24_BASE_LSB  17
`define A24_SLOT_OFS  16
`define A32_BASE_LSB  25
`define A32_SLOT_LSB  23
`define BASE_BITS     7
`define LEVELS        7
`define SOURCES       8
`define NO_LEVEL      3'h0

`endif

/* File: vme_mezzanine_mem_irq_router.v */
// carrier logic: memory window decode and interrupt routing for four slots
//
// Contract
// - compare high address with seven base jumpers, fitted reads zero
// - base bits meet A17..A23 in A24 space, A25..A31 in A32 space
// - shipped base jumpers decode 0xD00000 in A24, 0xD0000000 in A32
// - address A1..A23 passes straight to the slots, no remap, no waits
// - window is four times the per-slot size of the largest module
// - slot A at base, each next slot one slot size higher
// - A24 decode only while the standard space jumper is fitted
// - only one space at a time; both enables fitted decodes nothing
// - each slot raises two requests; module gives vector on acknowledge
// - levels follow bus priority, level 7 highest, level 1 lowest
// - default map: A to 1,2; B to 3,4; C to 5,6; D0 to 7; D1 none
// - default acknowledge: 7 to D0, 6,5 to C, 4,3 to B, 2,1 to A
// - acknowledge map is exact inverse of the request map
// - jumpers give one-to-one maps; encoder mode needs jumpers removed
// - slot A1 low for request 0, high for 1; else follows bus A1
//
// Local design decisions: the Wishbone interface to the registers and the address map.
`timescale 1ns/10ps
`include "router_map.vh"

module vme_mezzanine_mem_irq_router (
    input  wire        mclk,                 // 250 MHz clock
    input  wire        nrst,                 // sync reset, active low
    input  wire [7:0]  wb_adr_i,             // wishbone byte address
    input  wire [31:0] wb_dat_i,             // wishbone write data
    input  wire [3:0]  wb_sel_i,             // wishbone byte lanes
    input  wire        wb_we_i,              // wishbone write
    input  wire        wb_cyc_i,             // wishbone cycle
    input  wire        wb_stb_i,             // wishbone strobe
    output reg  [31:0] wb_dat_o,             // wishbone read data
    output reg         wb_ack_o,             // wishbone acknowledge
    output wire        irq_o,                // level interrupt
    input  wire [31:1] vme_addr,             // bus address lines
    input  wire        vme_as_n,             // address strobe
    input  wire        vme_am_a24,           // cycle in standard space
    input  wire        vme_am_a32,           // cycle in extended space
    input  wire        vme_iack_n,           // acknowledge cycle
    input  wire [1:0]  space_enable_jumpers, // [0] A24 [1] A32, fitted=0
    input  wire [2:0]  slot_size_jumpers,    // size pairs, fitted=0
    input  wire [7:0]  base_jumper_row_a,    // base, [0] unused, fitted=0
    input  wire [7:0]  request_map_target,   // per source, fitted=0
    input  wire [6:0]  ack_map_target,       // per level-1, fitted=0
    input  wire        encoder_fitted_n,     // encoder socket in use
    input  wire [23:0] encoder_map,          // 3-bit level per source
    input  wire [3:0]  slot_request_zero_n,  // request 0 per slot
    input  wire [3:0]  slot_request_one_n,   // request 1 per slot
    output reg  [7:1]  vme_irq_n,            // bus request levels
    output reg  [3:0]  slot_memory_select_n, // memory select per slot
    output reg  [3:0]  slot_irq_select_n,    // interrupt select per slot
    output reg  [3:0]  slot_a1,              // A1 to each slot
    output reg  [23:1] slot_addr,            // forwarded address
    output reg         carrier_answer        // a slot was selected
);

    // ************************************************************
    // input synchronisers
    // ************************************************************
    localparam SW = 31 + 4 + 2 + 3 + 8 + 8 + 7 + 1 + 24 + 8;

    wire [SW-1:0] raw_in;
    reg  [SW-1:0] sync1_r;
    reg  [SW-1:0] sync2_r;

    assign raw_in = {vme_addr, vme_as_n, vme_am_a24, vme_am_a32,
                     vme_iack_n, space_enable_jumpers, slot_size_jumpers,
                     base_jumper_row_a, request_map_target, ack_map_target,
                     encoder_fitted_n, encoder_map,
                     slot_request_one_n, slot_request_zero_n};

    // stage one is read by stage two only
    always @(posedge mclk) begin
        if (!nrst) begin
            sync1_r <= {SW{1'b1}};
            sync2_r <= {SW{1'b1}};
        end else begin
            sync1_r <= raw_in;
            sync2_r <= sync1_r;
        end
    end

    wire [31:1] addr;
    wire        as_n;
    wire        am24;
    wire        am32;
    wire        iack_n;
    wire [1:0]  sp_j;
    wire [2:0]  sz_j;
    wire [7:0]  base_j;
    wire [7:0]  req_j;
    wire [6:0]  ack_j;
    wire        enc_n;
    wire [23:0] enc_map;
    wire [3:0]  rq1_n;
    wire [3:0]  rq0_n;

    assign {addr, as_n, am24, am32, iack_n, sp_j, sz_j, base_j, req_j,
            ack_j, enc_n, enc_map, rq1_n, rq0_n} = sync2_r;

    // ************************************************************
    // timing and limitations
    // ************************************************************
    // every pin and jumper is sampled twice before any decode, so a
    // bus cycle shows on the slot side three edges after its strobe.
    // the slot selects and the interrupt levels are plain registered
    // copies of the decode; no state is kept between bus cycles, so a
    // strobe that bounces simply re-decodes the same address again.
    //
    // trade-off: the synchronisers add two edges of delay on every
    // path, in exchange for never decoding a half-settled address.
    // the host must hold the address and the strobe for at least three
    // edges, or the selected slot may see a select shorter than that.
    //
    // the jumpers are treated like any other asynchronous pin: moving
    // one while the bus is busy gives, at worst, one cycle of a mixed
    // old and new setting, after which the decode follows the new one.
    //
    // both memory spaces enabled, or the encoder socket used while a
    // request jumper is still fitted, is a bad configuration: every
    // decode is blocked and all levels are released, so a wrong setup
    // shows up as a dead carrier rather than as double-driven lines.
    //
    // the events feeding the status register are the rising edges of
    // the decode results, so one long bus cycle counts as one event.
    // a status bit set in the same cycle as a software clear survives.
    //
    // the forwarded address is not gated by cycle type; the slot only
    // looks at it while one of its selects is driven low.

    // ************************************************************
    // configuration
    // ************************************************************
    wire a24_en  = ~sp_j[0];
    wire a32_en  = ~sp_j[1];
    wire enc_fit = ~enc_n;
    wire sz_ok   = (sz_j >= `SZ_MIN) && (sz_j <= `SZ_MAX);
    // encoder and jumpers together would double-drive levels
    wire cfg_bad = (a24_en & a32_en) | (enc_fit & ~(&req_j));

    // ************************************************************
    // memory window decode
    // ************************************************************
    reg        m24;
    reg        m32;
    reg  [1:0] slot24;
    reg  [1:0] slot;
    reg        mem_hit;
    integer    b;

    always @* begin
        m24 = sz_ok;
        // base bit b+1 meets A(17+b); only bits above the window count
        for (b = 0; b < `BASE_BITS; b = b + 1) begin
            if (b > sz_j) begin
                if (addr[`A24_BASE_LSB + b] != base_j[b + 1]) begin
                    m24 = 1'b0;
                end
            end
        end
        // window is four slots; slot index sits just above slot size
        case (sz_j)
            3'h1:    slot24 = addr[`A24_SLOT_OFS + 2:`A24_SLOT_OFS + 1];
            3'h2:    slot24 = addr[`A24_SLOT_OFS + 3:`A24_SLOT_OFS + 2];
            3'h3:    slot24 = addr[`A24_SLOT_OFS + 4:`A24_SLOT_OFS + 3];
            3'h4:    slot24 = addr[`A24_SLOT_OFS + 5:`A24_SLOT_OFS + 4];
            3'h5:    slot24 = addr[`A24_SLOT_OFS + 6:`A24_SLOT_OFS + 5];
            default: slot24 = 2'h0;
        endcase
        m32 = (addr[31:`A32_BASE_LSB] == base_j[7:1]);
        if (am32) begin
            slot = addr[`A32_SLOT_LSB + 1:`A32_SLOT_LSB];
        end else begin
            slot = slot24;
        end
        mem_hit = ~as_n & iack_n & ~cfg_bad &
                  ((am24 & ~am32 & a24_en & m24) |
                   (am32 & ~am24 & a32_en & m32));
    end

    // ************************************************************
    // request routing
    // ************************************************************
    wire [7:0]  req_act;
    wire [23:0] lvl;

    assign req_act = {~rq1_n[3], ~rq0_n[3], ~rq1_n[2], ~rq0_n[2],
                      ~rq1_n[1], ~rq0_n[1], ~rq1_n[0], ~rq0_n[0]};

    genvar gi;
    generate
        for (gi = 0; gi < `SOURCES; gi = gi + 1) begin : g_src
            // source index as a sized constant; a genvar has no bit range
            localparam [2:0] SRC = gi;
            // straight-across jumper i gives level i+1; source 7 has none
            wire [2:0] jl = (gi < `LEVELS && !req_j[gi]) ?
                            SRC + 3'h1 : `NO_LEVEL;
            assign lvl[3*gi +: 3] = enc_fit ? enc_map[3*gi +: 3] : jl;
        end
    endgenerate

    wire [7:1] irq_nxt;

    generate
        for (gi = 1; gi <= `LEVELS; gi = gi + 1) begin : g_lvl
            localparam [2:0] LV = gi;
            wire [7:0] hit;
            genvar gs;
            for (gs = 0; gs < `SOURCES; gs = gs + 1) begin : g_s
                assign hit[gs] = req_act[gs] &
                                 (lvl[3*gs +: 3] == LV);
            end
            // line follows the module's own request, held until it lets go
            assign irq_nxt[gi] = ~(|hit) | cfg_bad;
        end
    endgenerate

    // ************************************************************
    // acknowledge steering
    // ************************************************************
    wire [2:0] ack_lvl = addr[3:1];
    reg        iack_hit;
    reg  [2:0] ack_src;
    reg        jmp_ok;
    integer    s;

    always @* begin
        iack_hit = 1'b0;
        ack_src  = 3'h0;
        jmp_ok   = 1'b1;
        if (!enc_fit && ack_lvl != `NO_LEVEL) begin
            jmp_ok = ~ack_j[ack_lvl - 3'h1];
        end
        // search the request map backwards; lowest requesting index wins, highest index if none requests
        for (s = `SOURCES - 1; s >= 0; s = s - 1) begin
            if (lvl[3*s +: 3] == ack_lvl && ack_lvl != `NO_LEVEL) begin
                if (req_act[s] || !iack_hit) begin
                    iack_hit = 1'b1;
                    ack_src  = s[2:0];
                end
            end
        end
        iack_hit = iack_hit & jmp_ok & ~as_n & ~iack_n & ~cfg_bad;
    end

    // ************************************************************
    // slot side outputs
    // ************************************************************
    always @(posedge mclk) begin
        if (!nrst) begin
            slot_memory_select_n <= `SEL_IDLE;
            slot_irq_select_n    <= `SEL_IDLE;
            slot_a1              <= 4'h0;
            slot_addr            <= 23'h000000;
            vme_irq_n            <= `IRQ_IDLE;
            carrier_answer       <= 1'b0;
        end else begin
            slot_addr <= addr[23:1];
            if (mem_hit) begin
                slot_memory_select_n <= ~(4'h1 << slot);
            end else begin
                slot_memory_select_n <= `SEL_IDLE;
            end
            if (iack_hit) begin
                slot_irq_select_n <= ~(4'h1 << ack_src[2:1]);
                slot_a1           <= {4{ack_src[0]}};
            end else begin
                slot_irq_select_n <= `SEL_IDLE;
                slot_a1           <= {4{addr[1]}};
            end
            vme_irq_n      <= irq_nxt;
            carrier_answer <= mem_hit | iack_hit;
        end
    end

    // ************************************************************
    // events and interrupt
    // ************************************************************
    reg  [`EV_W-1:0] status_r;
    reg  [`EV_W-1:0] mask_r;
    reg              mem_d_r;
    reg              iack_d_r;
    reg              noack_d_r;
    reg              cfg_d_r;
    wire             noack = ~as_n & ~iack_n & ~iack_hit;
    wire [`EV_W-1:0] ev;

    assign ev[`EV_MEM]   = mem_hit & ~mem_d_r;
    assign ev[`EV_IACK]  = iack_hit & ~iack_d_r;
    assign ev[`EV_NOACK] = noack & ~noack_d_r;
    assign ev[`EV_CFG]   = cfg_bad & ~cfg_d_r;
    assign irq_o         = |(status_r & mask_r);

    // ************************************************************
    // wishbone slave
    // ************************************************************
    wire             wb_req = wb_cyc_i & wb_stb_i & ~wb_ack_o;
    wire             wb_wr  = wb_req & wb_we_i & wb_sel_i[0];
    wire [`EV_W-1:0] clr    = (wb_wr && wb_adr_i == `OFS_STATUS) ?
                              wb_dat_i[`EV_W-1:0] : {`EV_W{1'b0}};
    reg  [31:0]      rd_nxt;

    always @* begin
        case (wb_adr_i)
            `OFS_STATUS:  rd_nxt = {28'h0000000, status_r};
            `OFS_MASK:    rd_nxt = {28'h0000000, mask_r};
            `OFS_JUMPERS: rd_nxt = {3'h0, enc_n, ack_j, req_j, base_j,
                                    sz_j, sp_j};
            `OFS_STATE:   rd_nxt = {16'h0000, carrier_answer, vme_irq_n,
                                    slot_irq_select_n,
                                    slot_memory_select_n};
            default:      rd_nxt = 32'h00000000;
        endcase
    end

    always @(posedge mclk) begin
        if (!nrst) begin
            status_r  <= `STATUS_RST;
            mask_r    <= `MASK_RST;
            mem_d_r   <= 1'b0;
            iack_d_r  <= 1'b0;
            noack_d_r <= 1'b0;
            cfg_d_r   <= 1'b0;
            wb_ack_o  <= 1'b0;
            wb_dat_o  <= 32'h00000000;
        end else begin
            mem_d_r   <= mem_hit;
            iack_d_r  <= iack_hit;
            noack_d_r <= noack;
            cfg_d_r   <= cfg_bad;
            // a new event beats a clear in the same cycle
            status_r  <= (status_r & ~clr) | ev;
            if (wb_wr && wb_adr_i == `OFS_MASK) begin
                mask_r <= wb_dat_i[`EV_W-1:0];
            end
            wb_ack_o <= wb_req;
            if (wb_req && !wb_we_i) begin
                wb_dat_o <= rd_nxt;
            end
        end
    end

endmodule // vme_mezzanine_mem_irq_router

/* File: mezz_slots.sv */
// behavioural model of the four mezzanine modules raising requests
`timescale 1ns/10ps
module mezz_slots (
    input  wire        mclk,      // clock
    input  wire        nrst,      // sync reset, active low
    input  wire [7:0]  raise,     // one-cycle ask, bit = source 2*slot+req
    input  wire [3:0]  mem_sel_n, // memory select per slot
    output logic [3:0] req0_n,    // request 0 per slot
    output logic [3:0] req1_n     // request 1 per slot
);
    logic [7:0] pend_r;
    // a request stays up until the host touches the module's memory
    always @(posedge mclk) begin
        for (int i = 0; i < 8; i++) begin
            if (!nrst)
                pend_r[i] <= 1'b0;
            else if (raise[i])
                pend_r[i] <= 1'b1;
            else if (!mem_sel_n[i/2])
                pend_r[i] <= 1'b0;
        end
    end
    assign req0_n = ~{pend_r[6], pend_r[4], pend_r[2], pend_r[0]};
    assign req1_n = ~{pend_r[7], pend_r[5], pend_r[3], pend_r[1]};
endmodule // mezz_slots

/* File: vme_mezzanine_mem_irq_router_asserts.sv */
// port checker for the carrier memory and interrupt router
`timescale 1ns/10ps
module router_checker (
    input wire        mclk,                 // clock
    input wire        nrst,                 // sync reset, active low
    input wire [31:1] vme_addr,             // bus address
    input wire        vme_as_n,             // address strobe
    input wire        vme_iack_n,           // acknowledge cycle
    input wire [3:0]  slot_request_zero_n,  // request 0 per slot
    input wire [3:0]  slot_request_one_n,   // request 1 per slot
    input wire [7:1]  vme_irq_n,            // bus levels
    input wire [3:0]  slot_memory_select_n, // memory selects
    input wire [3:0]  slot_irq_select_n,    // interrupt selects
    input wire [3:0]  slot_a1,              // A1 to slots
    input wire [23:1] slot_addr,            // forwarded address
    input wire        carrier_answer        // slot selected
);
    // ****
    // edges since reset, so a three-deep look back never sees reset
    // ****
    logic [2:0]  up_r;
    logic [23:1] lo_addr;
    logic        a1_pin;
    assign lo_addr = vme_addr[23:1];
    assign a1_pin = vme_addr[1];
    always @(posedge mclk)
        if (!nrst) up_r <= 3'h0;
        else if (up_r != 3'h7) up_r <= up_r + 3'h1;
    default clocking cb @(posedge mclk); endclocking
    default disable iff (!nrst);
    property p_fwd; up_r == 3'h7 |-> slot_addr == $past(lo_addr, 3);
    endproperty
    a_fwd: assert property (p_fwd) else $error("address not forwarded");
    property p_msel; $onehot0(~slot_memory_select_n); endproperty
    a_msel: assert property (p_msel) else $error("two memory selects");
    property p_isel; $onehot0(~slot_irq_select_n); endproperty
    a_isel: assert property (p_isel) else $error("two irq selects");
    property p_answer; carrier_answer ==
        (slot_memory_select_n != 4'hF || slot_irq_select_n != 4'hF);
    endproperty
    a_answer: assert property (p_answer) else $error("answer mismatch");
    property p_release;
        (&{slot_request_zero_n, slot_request_one_n}) [*4] |->
        vme_irq_n == 7'h7F;
    endproperty
    a_release: assert property (p_release) else $error("level held");
    property p_a1; up_r == 3'h7 && slot_memory_select_n != 4'hF |->
        slot_a1 == {4{$past(a1_pin, 3)}};
    endproperty
    a_a1: assert property (p_a1) else $error("A1 not following");
    property p_strobe; up_r == 3'h7 && slot_memory_select_n != 4'hF |->
        $past(vme_as_n, 3) == 1'b0 && $past(vme_iack_n, 3) == 1'b1;
    endproperty
    a_strobe: assert property (p_strobe) else $error("select w/o cycle");
    property p_drop; $rose(vme_as_n) |->
        ##3 (slot_memory_select_n == 4'hF && slot_irq_select_n == 4'hF);
    endproperty
    a_drop: assert property (p_drop) else $error("select stuck");
endmodule // router_checker

bind vme_mezzanine_mem_irq_router router_checker i_chk (
    .mclk(mclk), .nrst(nrst), .vme_addr(vme_addr), .vme_as_n(vme_as_n),
    .vme_iack_n(vme_iack_n), .slot_request_zero_n(slot_request_zero_n),
    .slot_request_one_n(slot_request_one_n), .vme_irq_n(vme_irq_n),
    .slot_memory_select_n(slot_memory_select_n),
    .slot_irq_select_n(slot_irq_select_n), .slot_a1(slot_a1),
    .slot_addr(slot_addr), .carrier_answer(carrier_answer)
);

/* File: vme_mezzanine_mem_irq_router_test.sv */
// self-checking bench for the carrier memory and interrupt router
`timescale 1ns/10ps
module vme_mezzanine_mem_irq_router_test;
    logic        mclk, nrst, we, cyc, stb, as_n, a24, a32, ik_n, a1_x;
    logic        ack, irq, ans;
    logic [7:0]  adr, base, rq_map, raise;
    logic [31:0] dat, wdo, ad;
    logic [31:1] va;
    logic [1:0]  spc;
    logic [2:0]  sz;
    logic [6:0]  ak_map;
    logic [7:1]  irq_n;
    logic [3:0]  msel_n, isel_n, a1, r0_n, r1_n;
    logic [23:1] saddr;
    logic [33:0] exp_q[$];
    logic [33:0] e;
    int          n_mismatch, n_tests, seed;
    vme_mezzanine_mem_irq_router i_dut (.mclk(mclk), .nrst(nrst),
        .wb_adr_i(adr), .wb_dat_i(dat), .wb_sel_i(4'hF), .wb_we_i(we),
        .wb_cyc_i(cyc), .wb_stb_i(stb), .wb_dat_o(wdo), .wb_ack_o(ack),
        .irq_o(irq), .vme_addr(va), .vme_as_n(as_n), .vme_am_a24(a24),
        .vme_am_a32(a32), .vme_iack_n(ik_n), .space_enable_jumpers(spc),
        .slot_size_jumpers(sz), .base_jumper_row_a(base),
        .request_map_target(rq_map), .ack_map_target(ak_map),
        .encoder_fitted_n(1'b1), .encoder_map(24'hFAC688),
        .slot_request_zero_n(r0_n), .slot_request_one_n(r1_n),
        .vme_irq_n(irq_n), .slot_memory_select_n(msel_n),
        .slot_irq_select_n(isel_n), .slot_a1(a1), .slot_addr(saddr),
        .carrier_answer(ans));
    mezz_slots i_mods (.mclk(mclk), .nrst(nrst), .raise(raise),
        .mem_sel_n(msel_n), .req0_n(r0_n), .req1_n(r1_n));
    initial begin
        mclk = 1'b0;
        forever #2 mclk = ~mclk;
    end
    task automatic stop_test();
        $display("mismatches %0d, comparisons %0d", n_mismatch, n_tests);
        if (n_mismatch == 0 && n_tests > 0)
            $display("Run complete: PASS");
        else
            $display("Run complete: FAIL");
        $finish;
    endtask
    task automatic wb(input logic w, input logic [7:0] a, input logic [31:0] d);
        int k;
        cyc <= 1'b1; stb <= 1'b1; we <= w; adr <= a; dat <= d;
        k = 0;
        do begin @(posedge mclk); k++; end while (ack !== 1'b1 && k < 20);
        if (k >= 20) begin n_mismatch++; stop_test(); end
        cyc <= 1'b0; stb <= 1'b0;
        @(posedge mclk);
    endtask
    // expectation is {irq, slot A1, read data}
    task automatic rd(input logic [7:0] a, input logic [31:0] x, input logic q);
        exp_q.push_back({q, a1_x, x});
        wb(1'b0, a, 32'h0);
    endtask
    task automatic vme(input logic [31:0] a, input logic m32, m24, ik);
        va <= a[31:1]; a32 <= m32; a24 <= m24; ik_n <= ~ik; as_n <= 1'b0;
        repeat (4) @(posedge mclk);
    endtask
    task automatic idle();
        va <= '0; as_n <= 1'b1; ik_n <= 1'b1; a24 <= 1'b0; a32 <= 1'b0;
        a1_x = 1'b0;
        repeat (4) @(posedge mclk);
    endtask
    always @(posedge mclk)
        if (ack === 1'b1 && we === 1'b0 && exp_q.size() > 0) begin
            e = exp_q.pop_front();
            n_tests++;
            if ({irq, a1[0], wdo} !== e) begin
                n_mismatch++;
                $display("BAD rd %h exp %h got %h", adr, e, {irq, a1[0], wdo});
            end
        end
    initial begin
        seed = 32'hf07e0b2d;
        {cyc, stb, we, dat, adr, va, raise, a24, a32, a1_x, nrst} = '0;
        {as_n, ik_n} = 2'b11;
        spc = 2'b01; sz = 3'b100; base = 8'hD0; rq_map = '0; ak_map = '0;
        n_mismatch = 0; n_tests = 0;
        repeat (6) @(posedge mclk);
        nrst <= 1'b1;
        repeat (4) @(posedge mclk);
        rd(8'h00, 0, 0); rd(8'h04, 0, 0); rd(8'h0C, 32'h7FFF, 0);
        rd(8'h10, 0, 0); rd(8'h08, 32'h10001A11, 0);
        for (int s = 0; s < 4; s++) begin
            ad = 32'hD0000000 | (s << 23) | ($random(seed) & 32'h7FFFFE);
            a1_x = ad[1];
            vme(ad, 1, 0, 0);
            rd(8'h0C, {16'h0, 8'hFF, 4'hF, ~(4'b1 << s)}, 0);
            idle();
        end
        vme(32'hD2000000, 1, 0, 0); rd(8'h0C, 32'h7FFF, 0);
        vme(32'h00D00000, 0, 1, 0); rd(8'h0C, 32'h7FFF, 0);
        idle();
        wb(1'b1, 8'h00, 32'hF);
        spc = 2'b10; base = 8'h40;
        for (int t = 0; t < 5; t++) begin
            ad = t == 0 ? 32'h00500000 : t == 1 ? 32'h003FFFFE :
                 t == 2 ? 32'h00800000 : t == 3 ? 32'h00700000 : 32'hD0500000;
            a1_x = ad[1];
            vme(ad, t == 4, t != 4, 0);
            rd(8'h0C, {16'h0, t == 0 || t == 3, 7'h7F, 4'hF,
                t == 0 ? 4'hD : t == 3 ? 4'h7 : 4'hF}, 0);
            idle();
        end
        spc = 2'b00;
        wb(1'b1, 8'h00, 32'hF);
        vme(32'hD0800000, 1, 0, 0); rd(8'h0C, 32'h7FFF, 0);
        idle();
        rd(8'h00, 32'h8, 0); wb(1'b1, 8'h04, 32'h8); rd(8'h00, 32'h8, 1);
        wb(1'b1, 8'h00, 32'h8); rd(8'h00, 0, 0); wb(1'b1, 8'h04, 0);
        spc = 2'b01; base = 8'hD0;
        for (int i = 0; i < 7; i++) begin
            raise <= 8'(1 << i);
            @(posedge mclk);
            raise <= '0;
            repeat (4) @(posedge mclk);
            rd(8'h0C, {16'h0, 1'b0, ~7'(1 << i), 8'hFF}, 0);
            a1_x = i[0];
            vme(32'((i + 1) << 1), 0, 0, 1);
            rd(8'h0C, {16'h0, 1'b1, ~7'(1 << i), ~4'(1 << (i / 2)), 4'hF},
               0);
            idle();
            vme(32'hD0000000 | ((i / 2) << 23), 1, 0, 0);
            repeat (4) @(posedge mclk);
            rd(8'h0C, {16'h0, 8'hFF, 4'hF, ~4'(1 << (i / 2))}, 0);
            idle();
        end
        wb(1'b1, 8'h00, 32'hF);
        raise <= 8'h80;
        @(posedge mclk);
        raise <= '0;
        repeat (4) @(posedge mclk);
        rd(8'h0C, 32'h7FFF, 0);
        vme(32'h0, 0, 0, 1); rd(8'h0C, 32'h7FFF, 0);
        idle();
        ak_map = 7'b0000100;
        raise <= 8'h04;
        @(posedge mclk);
        raise <= '0;
        a1_x = 1'b1;
        vme(32'h6, 0, 0, 1); rd(8'h0C, 32'h7BFF, 0);
        idle();
        rd(8'h00, 32'h4, 0);
        stop_test();
    end
endmodule // vme_mezzanine_mem_irq_router_test
